// ==== design/ptr_table_reader.sv ====
/*
  Program store, program counter, table-read path and serial programming port.
  Assumes the core holds table_req low while table_busy is high and keeps
  prog_serial_clock quiet unless prog_enable is high.
*/
`timescale 1ns/10ps
module ptr_table_reader
  import ptr_pkg::*;
#(
  parameter int ADDR_W = PTR_ADDR_W,
  parameter int WORD_W = PTR_WORD_W
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              pc_load,
  input  wire logic [ADDR_W-1:0] pc_load_addr,
  output logic [ADDR_W-1:0]      pc,
  output logic [WORD_W-1:0]      instr,
  output logic                   instr_valid,
  input  wire logic              table_req,
  input  wire ptr_tbl_req_t      table_cmd,
  input  wire logic [7:0]        tblp,
  input  wire logic [7:0]        tbhp,
  output logic                   table_busy,
  output logic                   table_wb_valid,
  output ptr_tbl_wb_t            table_wb,
  input  wire logic              table_high_byte_latch_wr,
  input  wire logic [7:0]        table_high_byte_latch_wdata,
  output logic [7:0]             table_high_byte_latch,
  input  wire logic              prog_enable,
  input  wire logic              prog_serial_clock,
  input  wire logic              prog_serial_data_in,
  output logic                   prog_serial_data_out,
  output logic                   prog_serial_data_oe
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  ptr_state_t        state_q;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] fetch_addr;
  logic [WORD_W-1:0] rd_q;
  ptr_tbl_req_t      cmd_q;
  logic              tbl_take;
  logic [7:0]        table_high_byte_latch_q;
  ptr_tbl_wb_t       wb_q;
  logic              wb_valid_q;
  logic              ivalid_q;
  logic              sck_q;
  logic              sck_rise;
  logic              sck_fall;
  logic [4:0]        bit_cnt_q;
  logic [ADDR_W-1:0] icp_addr_q;
  logic [WORD_W-1:0] icp_sh_q;
  logic              icp_cmd_q;

  assign tbl_take   = ce && (state_q == PTR_ST_RUN) && table_req;
  assign table_busy = (state_q == PTR_ST_TBL);
  // Table read borrows the fetch port, so the fetch stalls for both cycles of the table read
  assign fetch_addr = tbl_take ? ptr_tbl_addr(table_cmd.last_page, tblp,
                                              tbhp)
                               : pc_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PTR_ST_RUN;
    end else if (ce) begin
      case (state_q)
        PTR_ST_RUN: if (tbl_take) state_q <= PTR_ST_TBL;
        PTR_ST_TBL: state_q <= PTR_ST_RUN;
        default:    state_q <= PTR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PTR_RESET_VEC;
    end else if (ce) begin
      if (pc_load) begin
        pc_q <= pc_load_addr;
      end else if (state_q == PTR_ST_RUN && !tbl_take) begin
        pc_q <= pc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      rd_q <= mem[fetch_addr];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ivalid_q <= 1'b0;
    end else if (ce) begin
      // Dummy slot while the table word or a new target is fetched
      ivalid_q <= (state_q == PTR_ST_RUN) && !tbl_take && !pc_load;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
    end else if (tbl_take) begin
      cmd_q <= table_cmd;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid_q <= 1'b0;
      wb_q       <= '0;
    end else if (ce) begin
      wb_valid_q <= 1'b0;
      if (state_q == PTR_ST_TBL) begin
        wb_valid_q       <= 1'b1;
        wb_q.low_byte    <= rd_q[7:0];
        wb_q.dest        <= cmd_q.dest;
        wb_q.sector      <= cmd_q.extended ? cmd_q.sector
                                           : PTR_SECTOR0;
      end
    end
  end

  // Table result wins over a software write in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      table_high_byte_latch_q <= PTR_TABLE_HIGH_BYTE_LATCH_RST;
    end else if (ce) begin
      if (state_q == PTR_ST_TBL) begin
        table_high_byte_latch_q <= rd_q[15:8];
      end else if (table_high_byte_latch_wr) begin
        table_high_byte_latch_q <= table_high_byte_latch_wdata;
      end
    end
  end

  assign pc                    = pc_q;
  assign instr                 = rd_q;
  assign instr_valid           = ivalid_q;
  assign table_wb_valid        = wb_valid_q;
  assign table_wb              = wb_q;
  assign table_high_byte_latch = table_high_byte_latch_q;

  // Serial programming: command, 12 address bits, 16 data bits, MSB first
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
    end else if (ce) begin
      sck_q <= prog_serial_clock;
    end
  end
  assign sck_rise = ce && prog_serial_clock && !sck_q;
  assign sck_fall = ce && !prog_serial_clock && sck_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q  <= '0;
      icp_cmd_q  <= 1'b0;
      icp_addr_q <= '0;
    end else if (ce && !prog_enable) begin
      // Gated by ce too, so a frozen core keeps its frame position
      bit_cnt_q <= '0;
    end else if (sck_rise) begin
      bit_cnt_q <= (bit_cnt_q == PTR_ICP_FRAME_END - 1'b1) ? 5'h00
                                                         : bit_cnt_q + 1'b1;
      if (bit_cnt_q == 5'h00) begin
        icp_cmd_q <= prog_serial_data_in;
      end else if (bit_cnt_q < PTR_ICP_ADDR_END) begin
        icp_addr_q <= {icp_addr_q[ADDR_W-2:0], prog_serial_data_in};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      icp_sh_q <= '0;
    end else if (sck_rise && bit_cnt_q == PTR_ICP_ADDR_END - 1'b1
                 && icp_cmd_q != PTR_ICP_CMD_WR) begin
      icp_sh_q <= mem[{icp_addr_q[ADDR_W-2:0], prog_serial_data_in}];
    end else if (sck_rise && bit_cnt_q >= PTR_ICP_ADDR_END
                 && icp_cmd_q == PTR_ICP_CMD_WR) begin
      icp_sh_q <= {icp_sh_q[WORD_W-2:0], prog_serial_data_in};
    end else if (sck_fall && bit_cnt_q > PTR_ICP_ADDR_END
                 && icp_cmd_q != PTR_ICP_CMD_WR) begin
      icp_sh_q <= {icp_sh_q[WORD_W-2:0], 1'b0};
    end
  end

  // Store written on the last rising edge of a write frame
  always_ff @(posedge core_clk) begin
    if (prog_enable && sck_rise && icp_cmd_q == PTR_ICP_CMD_WR
        && bit_cnt_q == PTR_ICP_FRAME_END - 1'b1) begin
      mem[icp_addr_q] <= {icp_sh_q[WORD_W-2:0],
                          prog_serial_data_in};
    end
  end

  assign prog_serial_data_oe  = prog_enable && icp_cmd_q != PTR_ICP_CMD_WR
                                && bit_cnt_q >= PTR_ICP_ADDR_END;
  assign prog_serial_data_out = icp_sh_q[WORD_W-1];

  property p_reset_vec;
    @(posedge core_clk) $rose(rstn) |-> pc_q == PTR_RESET_VEC;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("pc not at vector");

  property p_two_cycles;
    @(posedge core_clk) disable iff (!rstn)
      tbl_take ##1 ce |-> table_busy && !wb_valid_q
                          ##1 wb_valid_q && !table_busy;
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("table op not 2 cycles");

  property p_low_byte;
    @(posedge core_clk) disable iff (!rstn)
      ce && state_q == PTR_ST_TBL |=>
        wb_valid_q && wb_q.low_byte == $past(rd_q[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte wrong");

  property p_high_byte;
    @(posedge core_clk) disable iff (!rstn)
      ce && state_q == PTR_ST_TBL |=> table_high_byte_latch_q == $past(rd_q[15:8]);
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("high byte wrong");

  property p_sector;
    @(posedge core_clk) disable iff (!rstn)
      wb_valid_q && !cmd_q.extended |-> wb_q.sector == PTR_SECTOR0;
  endproperty
  a_sector: assert property (p_sector)
    else $error("basic fetch not sector 0");

  property p_last_page;
    @(posedge core_clk) disable iff (!rstn)
      tbl_take && table_cmd.last_page |-> fetch_addr == {4'hF, tblp};
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page addr wrong");

  property p_normal_addr;
    @(posedge core_clk) disable iff (!rstn)
      tbl_take && !table_cmd.last_page |-> fetch_addr == {tbhp[3:0], tblp};
  endproperty
  a_normal_addr: assert property (p_normal_addr)
    else $error("table addr wrong");

  property p_dummy;
    @(posedge core_clk) disable iff (!rstn)
      ce && (tbl_take || pc_load) |=> !ivalid_q;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("no dummy cycle");

  property p_hold;
    @(posedge core_clk) disable iff (!rstn)
      !(ce && (state_q == PTR_ST_TBL || table_high_byte_latch_wr)) |=> $stable(table_high_byte_latch_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("holding latch changed");

  property p_sw_write;
    @(posedge core_clk) disable iff (!rstn)
      ce && table_high_byte_latch_wr && state_q != PTR_ST_TBL |=>
        table_high_byte_latch_q == $past(table_high_byte_latch_wdata);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("latch write lost");

  c_table_read: cover property (@(posedge core_clk)
    wb_valid_q && cmd_q.extended);
  c_last_page:  cover property (@(posedge core_clk)
    tbl_take && table_cmd.last_page);
  c_icp_read:   cover property (@(posedge core_clk) prog_serial_data_oe);
endmodule

// ==== common/ptr_pkg.sv ====
/*
  Shared constants and carrier types for the program store and table reader.
  Assumes a single core clock domain and a core that issues table reads.
*/
package ptr_pkg;
  localparam int          PTR_ADDR_W     = 12;
  localparam int          PTR_WORD_W     = 16;
  localparam int          PTR_DEPTH      = 4096;
  localparam logic [11:0] PTR_RESET_VEC  = 12'h000;
  localparam logic [11:0] PTR_LAST_PAGE  = 12'hF00;
  localparam logic [7:0]  PTR_TABLE_HIGH_BYTE_LATCH_RST   = 8'h00;
  localparam logic [1:0]  PTR_SECTOR0    = 2'h0;
  localparam int          PTR_TBL_CYCLES = 2;
  // Serial programming frame: command bit, address, data word
  localparam logic [4:0]  PTR_ICP_ADDR_END = 5'h0D;
  localparam logic [4:0]  PTR_ICP_FRAME_END = 5'h1D;
  localparam logic        PTR_ICP_CMD_WR = 1'b1;

  typedef enum logic [1:0] {
    PTR_ST_RUN = 2'b01,
    PTR_ST_TBL = 2'b10
  } ptr_state_t;

  typedef struct packed {
    logic       last_page;
    logic       extended;
    logic [1:0] sector;
    logic [7:0] dest;
  } ptr_tbl_req_t;

  typedef struct packed {
    logic [1:0] sector;
    logic [7:0] dest;
    logic [7:0] low_byte;
  } ptr_tbl_wb_t;

  function automatic logic [11:0] ptr_tbl_addr(input logic       last_page,
                                               input logic [7:0] tblp,
                                               input logic [7:0] tbhp);
    ptr_tbl_addr = last_page ? {PTR_LAST_PAGE[11:8], tblp}
                             : {tbhp[3:0], tblp};
  endfunction
endpackage

// ==== sim/ptr_prog_model.sv ====
/*
  Serial programmer model that loads the program store word by word.
  Assumes the device samples the serial clock against core_clk.
*/
`timescale 1ns/10ps
module ptr_prog_model
  import ptr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic prog_serial_sense,
  output logic      prog_enable,
  output logic      prog_serial_clock,
  output logic      prog_serial_data
);
  initial begin
    prog_enable       = 1'b0;
    prog_serial_clock = 1'b0;
    prog_serial_data  = 1'b0;
  end

  // Three core clocks per half period, above the two-clock minimum
  task automatic half_wait();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic write_word(input logic [11:0] addr,
                            input logic [15:0] data);
    logic [28:0] frame;
    frame       = {PTR_ICP_CMD_WR, addr, data};
    prog_enable = 1'b1;
    for (int i = 28; i >= 0; i--) begin
      prog_serial_data  = frame[i];
      half_wait();
      prog_serial_clock = 1'b1;
      half_wait();
      prog_serial_clock = 1'b0;
    end
    // Released line shows the inverse, so a stale bit cannot pass
    prog_serial_data = ~prog_serial_data;
    half_wait();
    prog_enable = 1'b0;
    // Let the device see the enable low before the next frame
    half_wait();
  endtask

  task automatic read_word(input  logic [11:0] addr,
                           output logic [15:0] data);
    logic [12:0] head;
    head        = {~PTR_ICP_CMD_WR, addr};
    data        = '0;
    prog_enable = 1'b1;
    for (int i = 28; i >= 0; i--) begin
      if (i >= 16) begin
        prog_serial_data = head[i-16];
      end else if (i == 15) begin
        // Released line shows the inverse of the last bit driven
        prog_serial_data = ~prog_serial_data;
      end
      half_wait();
      if (i < 16) begin
        data[i] = prog_serial_sense;
      end
      prog_serial_clock = 1'b1;
      half_wait();
      prog_serial_clock = 1'b0;
    end
    prog_enable = 1'b0;
    half_wait();
  endtask
endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the program store and table reader.
  Assumes the programmer model loads the store before any fetch check.
*/
`timescale 1ns/10ps
module testbench;
  import ptr_pkg::*;
  logic         core_clk, rstn, ce, pc_load, table_req, table_high_byte_latch_wr;
  logic [11:0]  pc_load_addr, pc;
  logic [15:0]  instr;
  logic         instr_valid, table_busy, table_wb_valid;
  ptr_tbl_req_t table_cmd;
  ptr_tbl_wb_t  table_wb;
  logic [7:0]   tblp, tbhp, table_high_byte_latch_wdata, table_high_byte_latch;
  logic         pen, sclk, pm_data, sd_in, sd_out, sd_oe;
  int           bad_count = 0;
  int           n_tests = 0;

  assign sd_in = sd_oe ? sd_out : pm_data;

  ptr_table_reader ptr_table_reader_i (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .pc(pc), .instr(instr),
    .instr_valid(instr_valid), .table_req(table_req),
    .table_cmd(table_cmd), .tblp(tblp), .tbhp(tbhp),
    .table_busy(table_busy), .table_wb_valid(table_wb_valid),
    .table_wb(table_wb), .table_high_byte_latch_wr(table_high_byte_latch_wr), .table_high_byte_latch_wdata(table_high_byte_latch_wdata),
    .table_high_byte_latch(table_high_byte_latch), .prog_enable(pen),
    .prog_serial_clock(sclk), .prog_serial_data_in(sd_in),
    .prog_serial_data_out(sd_out), .prog_serial_data_oe(sd_oe));

  ptr_prog_model ptr_prog_model_i (
    .core_clk(core_clk), .prog_serial_sense(sd_in), .prog_enable(pen),
    .prog_serial_clock(sclk), .prog_serial_data(pm_data));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic test_reset();
    check("pc in reset", 16'h0000, pc);
    check("latch in reset", 16'h0000, table_high_byte_latch);
    check("busy in reset", 16'h0000, table_busy);
    rstn = 1'b1;
    tick();
    check("pc after reset", 16'h0001, pc);
    $display("test reset done");
  endtask

  task automatic test_fetch();
    logic [11:0] p;
    pc_load      = 1'b1;
    pc_load_addr = 12'h010;
    tick();
    pc_load = 1'b0;
    check("pc loaded", 16'h0010, pc);
    check("dummy slot", 16'h0000, instr_valid);
    tick();
    check("instr", 16'hABCD, instr);
    check("instr valid", 16'h0001, instr_valid);
    // Frozen clock enable must hold the counter
    ce = 1'b0;
    p  = pc;
    tick();
    check("pc frozen", p, pc);
    ce = 1'b1;
    $display("test fetch done");
  endtask

  task automatic tbl_read(input ptr_tbl_req_t cmd, input logic [7:0] lo,
                          input logic [7:0] hi, input logic [15:0] word);
    table_cmd = cmd;
    tblp      = lo;
    tbhp      = hi;
    table_req = 1'b1;
    tick();
    table_req = 1'b0;
    check("busy", 16'h0001, table_busy);
    check("valid in dummy", 16'h0000, instr_valid);
    tick();
    check("wb valid", 16'h0001, table_wb_valid);
    check("low byte", word[7:0], table_wb.low_byte);
    check("dest", cmd.dest, table_wb.dest);
    check("sector", cmd.extended ? cmd.sector : 2'h0, table_wb.sector);
    check("latch", word[15:8], table_high_byte_latch);
  endtask

  task automatic test_table();
    // Back to back: each read starts in the same cycle that presents the last result
    tbl_read('{1'b0, 1'b1, 2'h2, 8'h44}, 8'h05, 8'h03, 16'h5C3D);
    tbl_read('{1'b1, 1'b0, 2'h1, 8'h45}, 8'h06, 8'h03, 16'h1A2B);
    tbl_read('{1'b0, 1'b0, 2'h0, 8'h46}, 8'hFF, 8'hFF, 16'h9E81);
    repeat (3) tick();
    check("latch held", 16'h009E, table_high_byte_latch);
    $display("test table done");
  endtask

  task automatic test_latch();
    table_high_byte_latch_wr    = 1'b1;
    table_high_byte_latch_wdata = 8'h77;
    tick();
    table_high_byte_latch_wr = 1'b0;
    tick();
    check("latch write", 16'h0077, table_high_byte_latch);
    repeat (4) tick();
    check("latch kept", 16'h0077, table_high_byte_latch);
    $display("test latch done");
  endtask

  task automatic test_readback();
    logic [15:0] w;
    ptr_prog_model_i.read_word(12'hF06, w);
    check("readback", 16'h1A2B, w);
    check("data oe released", 16'h0000, sd_oe);
    ptr_prog_model_i.read_word(12'h305, w);
    check("readback 2", 16'h5C3D, w);
    $display("test readback done");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    pc_load = 1'b0;
    pc_load_addr = 12'h000;
    table_req = 1'b0;
    table_cmd = '0;
    tblp = 8'h00;
    tbhp = 8'h00;
    table_high_byte_latch_wr = 1'b0;
    table_high_byte_latch_wdata = 8'h00;
    repeat (20) tick();
    test_reset();
    ptr_prog_model_i.write_word(12'h010, 16'hABCD);
    ptr_prog_model_i.write_word(12'h305, 16'h5C3D);
    ptr_prog_model_i.write_word(12'hF06, 16'h1A2B);
    ptr_prog_model_i.write_word(12'hFFF, 16'h9E81);
    test_fetch();
    test_table();
    test_latch();
    test_readback();
    report_and_stop();
  end
endmodule
